// ===== hw/hcs_pkg.sv
// Shared constants and types of the Hall conversion sequencer
package hcs_pkg;
  // Clock and timing
  localparam int CLK_MHZ            = 250;
  localparam int T_SPIN_NS          = 200;
  localparam int T_CONV_NS          = 200;
  localparam int T_WAKE_STBY_NS     = 100;
  localparam int T_WAKE_SLEEP_NS    = 800;
  localparam int T_WAKE_DUTY_NS     = 400;
  localparam int SPIN_CYC           = (T_SPIN_NS * CLK_MHZ + 999) / 1000;
  localparam int CONV_CYC           = (T_CONV_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_STBY_CYC      = (T_WAKE_STBY_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_SLEEP_CYC     = (T_WAKE_SLEEP_NS * CLK_MHZ + 999) / 1000;
  localparam int WAKE_DUTY_CYC      = (T_WAKE_DUTY_NS * CLK_MHZ + 999) / 1000;

  // SPI frame: 1 bit read flag, 7 bit address, 16 bit data
  localparam int FRAME_BITS         = 24;
  localparam int CMD_BITS           = 8;

  // Register offsets
  localparam logic [6:0] ADDR_DEV_CFG  = 7'h00;
  localparam logic [6:0] ADDR_SENS_CFG = 7'h01;
  localparam logic [6:0] ADDR_STATUS   = 7'h02;
  localparam logic [6:0] ADDR_TRIGGER  = 7'h03;
  localparam logic [6:0] ADDR_X_RES    = 7'h08;
  localparam logic [6:0] ADDR_Y_RES    = 7'h09;
  localparam logic [6:0] ADDR_Z_RES    = 7'h0a;
  localparam logic [6:0] ADDR_VLEN     = 7'h14;

  // Reset values
  localparam logic [15:0] DEV_CFG_RST  = 16'h0000;
  localparam logic [15:0] SENS_CFG_RST = 16'h0000;
  localparam logic [15:0] VLEN_RST     = 16'h0000;

  // Operating modes
  localparam logic [2:0] MODE_TRIG_STBY  = 3'b000;
  localparam logic [2:0] MODE_TRIG_SLEEP = 3'b001;
  localparam logic [2:0] MODE_CONT       = 3'b010;
  localparam logic [2:0] MODE_TRIG_DUTY  = 3'b011;

  // Trigger sources
  localparam logic [1:0] TSRC_SPI   = 2'b00;
  localparam logic [1:0] TSRC_CS    = 2'b01;
  localparam logic [1:0] TSRC_ALERT = 2'b10;

  // Channel select codes beyond the plain X/Y/Z bit mask
  localparam logic [3:0] SEL_XZX = 4'b1101;
  localparam logic [3:0] SEL_YZY = 4'b1110;

  localparam logic [1:0] CH_X = 2'd0;
  localparam logic [1:0] CH_Y = 2'd1;
  localparam logic [1:0] CH_Z = 2'd2;
  localparam logic [1:0] SLOT_END = 2'd3;

  typedef struct packed {
    logic [5:0] pad_hi;
    logic [1:0] drift_comp;
    logic       pad_mid;
    logic [2:0] mode;
    logic [1:0] pad_lo;
    logic [1:0] trig_src;
  } hcs_dev_cfg_t;

  typedef struct packed {
    logic        en;
    logic [1:0]  chan;
    logic [15:0] data;
  } hcs_res_wr_t;
endpackage

// ===== hw/hcs_result_mem.sv
// Result store, one word per axis, registered read port
`timescale 1ns/10ps
`default_nettype none
module hcs_result_mem
  import hcs_pkg::*;
(
  input  wire logic        clock,
  input  wire hcs_res_wr_t wr,
  input  wire logic [1:0]  rd_addr,
  output var  logic [15:0] rd_data
);
  logic [15:0] mem [4];

  always_ff @(posedge clock) begin
    if (wr.en) begin
      mem[wr.chan] <= wr.data;
    end
    rd_data <= mem[rd_addr];
  end
endmodule
`default_nettype wire

// ===== hw/hcs_sequencer.sv
// Hall conversion sequencer with SPI register access
// How it works
// - Continuous code keeps the sequence running with no further trigger.
// - Spin stage starts the next sample while the converter digitises.
// - Each digitised sample lands in its own axis result register.
// - Continuous samples come every spin interval plus one cycle per skipped slot, not every full latency.
// - Codes 000, 001 and 011 make the device a triggered converter.
// - Trigger by SPI command, alert edge or chip select falling.
// - Wake delay before a triggered run depends on the operating mode.
// - Code 1101 converts X, Z, then X again.
// - Middle sample completes exactly halfway between first and last.
// - Code 1110 converts Y, Z, then Y again.
// - Drift compensation resets to 00, which passes samples unchanged.
// - Read-only vector length register, reset to zero.
// - Results change only when a conversion completes.
`timescale 1ns/10ps
`default_nettype none
module hcs_sequencer
  import hcs_pkg::*;
(
  input  wire logic        clock,
  input  wire logic        rst_b,
  input  wire logic        spi_sclk,
  input  wire logic        spi_cs_b,
  input  wire logic        spi_mosi,
  input  wire logic        alert_b,
  input  wire logic [15:0] adc_data,
  output var  logic        spi_miso,
  output var  logic        spi_miso_oe,
  output var  logic        afe_spin_go,
  output var  logic [1:0]  afe_channel,
  output var  logic        adc_go,
  output var  logic        conv_active
);
  typedef enum logic [1:0] {ST_IDLE, ST_WARM, ST_RUN} hcs_state_t;

  // Pin synchronisers: sclk, cs_b, mosi, alert_b
  logic [3:0] pin_s1, pin_s2, pin_s3;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1 <= 4'b1110;
      pin_s2 <= 4'b1110;
      pin_s3 <= 4'b1110;
    end else begin
      pin_s1 <= {alert_b, spi_mosi, spi_cs_b, spi_sclk};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end
  wire sclk_rise  = pin_s2[0] & ~pin_s3[0];
  wire sclk_fall  = ~pin_s2[0] & pin_s3[0];
  wire cs_fall    = ~pin_s2[1] & pin_s3[1];
  wire cs_rise    = pin_s2[1] & ~pin_s3[1];
  wire cs_active  = ~pin_s2[1];
  wire mosi_s     = pin_s2[2];
  wire alert_fall = ~pin_s2[3] & pin_s3[3];

  // Registers
  hcs_dev_cfg_t dev_cfg;
  logic [15:0]  sens_cfg;
  logic [15:0]  vlen;
  logic [15:0]  x_abs, y_abs;
  wire  [3:0]   axis_channel_select = sens_cfg[3:0];

  // SPI slave
  logic [4:0]  bit_cnt;
  logic [23:0] rx;
  logic        cmd_rd;
  logic [6:0]  cmd_addr;
  logic        ld1, ld2;
  logic [15:0] tx;
  logic [15:0] mem_rd_data;
  wire cmd_done = cs_active & sclk_rise & (bit_cnt == 5'(CMD_BITS - 1));
  wire wr_commit = cs_rise & (bit_cnt == 5'(FRAME_BITS)) & ~cmd_rd;
  wire [15:0] wr_data = rx[15:0];
  wire wr_dev  = wr_commit & (cmd_addr == ADDR_DEV_CFG);
  wire wr_sens = wr_commit & (cmd_addr == ADDR_SENS_CFG);
  wire wr_trig = wr_commit & (cmd_addr == ADDR_TRIGGER);
  wire is_res  = (cmd_addr == ADDR_X_RES) | (cmd_addr == ADDR_Y_RES) | (cmd_addr == ADDR_Z_RES);

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt  <= 5'd0;
      rx       <= 24'h00_0000;
      cmd_rd   <= 1'b0;
      cmd_addr <= 7'h00;
    end else if (cs_fall) begin
      bit_cnt <= 5'd0;
    end else if (cs_active && sclk_rise) begin
      rx <= {rx[22:0], mosi_s};
      if (bit_cnt != 5'(FRAME_BITS)) begin
        bit_cnt <= bit_cnt + 5'd1;
      end
      if (cmd_done) begin
        cmd_rd   <= rx[6];
        cmd_addr <= {rx[5:0], mosi_s};
      end
    end
  end

  // Read data mux, results come from the registered memory port
  logic [15:0] rd_mux;
  hcs_state_t  state;
  logic        spin_busy, conv_busy;
  always_comb begin
    rd_mux = 16'h0000;
    if (is_res) begin
      rd_mux = mem_rd_data;
    end else if (cmd_addr == ADDR_DEV_CFG) begin
      rd_mux = dev_cfg;
    end else if (cmd_addr == ADDR_SENS_CFG) begin
      rd_mux = sens_cfg;
    end else if (cmd_addr == ADDR_STATUS) begin
      rd_mux = {13'h0000, conv_busy, spin_busy, state != ST_IDLE};
    end else if (cmd_addr == ADDR_VLEN) begin
      rd_mux = vlen;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ld1         <= 1'b0;
      ld2         <= 1'b0;
      tx          <= 16'h0000;
      spi_miso    <= 1'b0;
      spi_miso_oe <= 1'b0;
    end else begin
      ld1         <= cmd_done;
      ld2         <= ld1;
      spi_miso_oe <= cs_active;
      if (cs_fall) begin
        spi_miso <= 1'b0;
        tx       <= 16'h0000;
      end else if (ld2) begin
        tx <= rd_mux;
      end else if (cs_active && sclk_fall && bit_cnt >= 5'(CMD_BITS)) begin
        spi_miso <= tx[15];
        tx       <= {tx[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dev_cfg  <= DEV_CFG_RST;
      sens_cfg <= SENS_CFG_RST;
    end else begin
      if (wr_dev) begin
        dev_cfg <= wr_data;
      end
      if (wr_sens) begin
        sens_cfg <= wr_data;
      end
    end
  end

  // Mode decode and trigger events
  wire mode_cont = dev_cfg.mode == MODE_CONT;
  wire mode_trig = (dev_cfg.mode == MODE_TRIG_STBY) | (dev_cfg.mode == MODE_TRIG_SLEEP)
                 | (dev_cfg.mode == MODE_TRIG_DUTY);
  wire trig_evt = (wr_trig & (dev_cfg.trig_src == TSRC_SPI))
                | (cs_fall & (dev_cfg.trig_src == TSRC_CS))
                | (alert_fall & (dev_cfg.trig_src == TSRC_ALERT));
  wire [7:0] wake_len = (dev_cfg.mode == MODE_TRIG_SLEEP) ? 8'(WAKE_SLEEP_CYC)
                      : (dev_cfg.mode == MODE_TRIG_DUTY)  ? 8'(WAKE_DUTY_CYC)
                      : 8'(WAKE_STBY_CYC);

  // Channel slot table
  logic [1:0] spin_slot;
  logic       slot_ok;
  logic [1:0] slot_chan;
  wire pseudo = (axis_channel_select == SEL_XZX) | (axis_channel_select == SEL_YZY);
  wire [1:0] outer_chan = (axis_channel_select == SEL_XZX) ? CH_X : CH_Y;
  always_comb begin
    if (pseudo) begin
      slot_ok   = 1'b1;
      slot_chan = (spin_slot == 2'd1) ? CH_Z : outer_chan;
    end else begin
      slot_ok   = (spin_slot != SLOT_END) && axis_channel_select[spin_slot];
      slot_chan = spin_slot;
    end
  end

  // Two stage pipeline: spin/integrate then convert
  logic [7:0] spin_cnt, conv_cnt, warm_cnt;
  logic [1:0] spin_chan, conv_chan;
  wire spin_done  = spin_busy & (spin_cnt == 8'd0);
  wire conv_done  = conv_busy & (conv_cnt == 8'd0);
  wire hand       = spin_done & (~conv_busy | conv_done);
  wire spin_free  = ~spin_busy | hand;
  wire slot_step  = (state == ST_RUN) & spin_free & (spin_slot != SLOT_END);
  wire launch     = slot_step & slot_ok;
  wire seq_end    = (spin_slot == SLOT_END) & ~spin_busy & ~conv_busy;
  wire [1:0] next_slot = (spin_slot == 2'd2) ? (mode_cont ? 2'd0 : SLOT_END)
                                             : spin_slot + 2'd1;

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state    <= ST_IDLE;
      warm_cnt <= 8'd0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (mode_cont) begin
            state <= ST_RUN;
          end else if (mode_trig && trig_evt) begin
            state    <= ST_WARM;
            warm_cnt <= wake_len - 8'd1;
          end
        end
        ST_WARM: begin
          if (warm_cnt == 8'd0) begin
            state <= ST_RUN;
          end else begin
            warm_cnt <= warm_cnt - 8'd1;
          end
        end
        ST_RUN: begin
          if (seq_end) begin
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      spin_slot <= 2'd0;
      spin_busy <= 1'b0;
      spin_cnt  <= 8'd0;
      spin_chan <= CH_X;
    end else begin
      if (state == ST_RUN && seq_end) begin
        spin_slot <= 2'd0;
      end else if (slot_step) begin
        spin_slot <= next_slot;
      end
      if (launch) begin
        spin_busy <= 1'b1;
        spin_cnt  <= 8'(SPIN_CYC - 1);
        spin_chan <= slot_chan;
      end else if (hand) begin
        spin_busy <= 1'b0;
      end else if (spin_busy && spin_cnt != 8'd0) begin
        spin_cnt <= spin_cnt - 8'd1;
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      conv_busy <= 1'b0;
      conv_cnt  <= 8'd0;
      conv_chan <= CH_X;
    end else if (hand) begin
      conv_busy <= 1'b1;
      conv_cnt  <= 8'(CONV_CYC - 1);
      conv_chan <= spin_chan;
    end else if (conv_done) begin
      conv_busy <= 1'b0;
    end else if (conv_busy) begin
      conv_cnt <= conv_cnt - 8'd1;
    end
  end

  // Optional magnet drift compensation, 00 passes the sample through
  wire [15:0] comp_add = 16'($signed(adc_data) >>> (4'd8 - {2'b00, dev_cfg.drift_comp}));
  wire [15:0] comp_data = (dev_cfg.drift_comp == 2'b00) ? adc_data : adc_data + comp_add;

  hcs_res_wr_t res_wr;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      res_wr <= '0;
    end else begin
      res_wr.en   <= conv_done;
      res_wr.chan <= conv_chan;
      res_wr.data <= comp_data;
    end
  end

  hcs_result_mem u_mem (
    .clock   (clock),
    .wr      (res_wr),
    .rd_addr (cmd_addr[1:0]),
    .rd_data (mem_rd_data)
  );

  // Vector length estimate: max + min/2 of |X| and |Y|
  wire [15:0] wr_abs = res_wr.data[15] ? 16'(-res_wr.data) : res_wr.data;
  wire [15:0] nx = (res_wr.chan == CH_X) ? wr_abs : x_abs;
  wire [15:0] ny = (res_wr.chan == CH_Y) ? wr_abs : y_abs;
  wire [15:0] vmax = (nx > ny) ? nx : ny;
  wire [15:0] vmin = (nx > ny) ? ny : nx;
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      x_abs <= 16'h0000;
      y_abs <= 16'h0000;
      vlen  <= VLEN_RST;
    end else if (res_wr.en) begin
      x_abs <= nx;
      y_abs <= ny;
      vlen  <= vmax + {1'b0, vmin[15:1]};
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      afe_spin_go <= 1'b0;
      afe_channel <= CH_X;
      adc_go      <= 1'b0;
      conv_active <= 1'b0;
    end else begin
      afe_spin_go <= launch;
      adc_go      <= hand;
      conv_active <= state != ST_IDLE;
      if (launch) begin
        afe_channel <= slot_chan;
      end
    end
  end

  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  AST_CONT_START: assert property (state == ST_IDLE && mode_cont |=> state == ST_RUN)
    else $error("continuous mode did not start");
  AST_PIPE: assert property (conv_busy && mode_cont && pseudo && state == ST_RUN && !seq_end
                            |-> spin_busy || launch)
    else $error("spin stage idle while converting");
  AST_RES_CHAN: assert property (conv_done |=> res_wr.en && res_wr.chan == $past(conv_chan))
    else $error("result not written to its channel");
  AST_INTERVAL: assert property (launch && mode_cont && pseudo |-> ##50 (launch || !mode_cont || !pseudo))
    else $error("continuous update interval wrong");
  AST_TRIG_START: assert property (state == ST_IDLE && !mode_cont && mode_trig && trig_evt
                                   |=> state == ST_WARM)
    else $error("trigger ignored");
  AST_WAKE_STBY: assert property (state == ST_IDLE && dev_cfg.mode == MODE_TRIG_STBY && trig_evt
                                  |-> ##26 state == ST_RUN)
    else $error("standby wake delay wrong");
  AST_XZX: assert property (launch && axis_channel_select == SEL_XZX
                            |=> afe_channel == (($past(spin_slot) == 2'd1) ? CH_Z : CH_X))
    else $error("pseudo sequence channel order wrong");
  AST_MID: assert property (conv_done && pseudo && conv_chan != CH_Z
                            ##50 conv_done && conv_chan == CH_Z |-> ##50 conv_done)
    else $error("middle sample not centred");
  AST_YZY: assert property (launch && axis_channel_select == SEL_YZY && spin_slot != 2'd1
                            |=> afe_channel == CH_Y)
    else $error("outer sample not Y");
  AST_NO_COMP: assert property (conv_done && dev_cfg.drift_comp == 2'b00 |=> res_wr.data == $past(adc_data))
    else $error("sample altered without compensation");
  AST_VLEN_RO: assert property (!res_wr.en |=> $stable(vlen))
    else $error("vector length changed without a result");
  AST_RES_ONLY_DONE: assert property (res_wr.en |-> $past(conv_done))
    else $error("result written before completion");
  AST_IDLE_AFTER: assert property (state == ST_RUN && seq_end |=> state == ST_IDLE)
    else $error("triggered run did not end");

  COV_CONT: cover property (mode_cont && conv_done ##50 conv_done);
  COV_XZX: cover property (axis_channel_select == SEL_XZX && res_wr.en && res_wr.chan == CH_Z);
  COV_ALERT: cover property (state == ST_IDLE && alert_fall && dev_cfg.trig_src == TSRC_ALERT && mode_trig);
  COV_SPI_RD: cover property (ld2 && is_res);
endmodule
`default_nettype wire

// ===== testbench/hcs_spi_host.sv
// SPI controller model standing on the far side of the sequencer
`timescale 1ns/10ps
`default_nettype none
module hcs_spi_host
  import hcs_pkg::*;
(
  input  wire logic clock,
  input  wire logic spi_miso,
  output var  logic spi_sclk,
  output var  logic spi_cs_b,
  output var  logic spi_mosi
);
  localparam int HALF = 10;

  initial begin
    spi_sclk = 1'b0;
    spi_cs_b = 1'b1;
    spi_mosi = 1'b0;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // Mode 0 frame, MSB first, clock idles low between frames
  task automatic xfer(input logic [FRAME_BITS-1:0] w, output logic [15:0] r);
    r = 16'h0000;
    tick(1);
    spi_cs_b = 1'b0;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      spi_mosi = w[i];
      tick(HALF);
      spi_sclk = 1'b1;
      if (i < 16) r[i] = spi_miso;
      tick(HALF);
      spi_sclk = 1'b0;
    end
    tick(HALF);
    spi_cs_b = 1'b1;
    // Data line is driven to the inverse of its last bit after the frame
    spi_mosi = ~spi_mosi;
    tick(4);
  endtask
endmodule
`default_nettype wire

// ===== testbench/hcs_sequencer_tb_top.sv
// Self-checking bench of the Hall conversion sequencer
`timescale 1ns/10ps
`default_nettype none
module hcs_sequencer_tb_top
  import hcs_pkg::*;
;
  logic        clock;
  logic        rst_b;
  logic        alert_b;
  logic [15:0] adc_data = 16'h0000;
  wire logic   spi_sclk;
  wire logic   spi_cs_b;
  wire logic   spi_mosi;
  wire logic   spi_miso;
  wire logic   spi_miso_oe;
  wire logic   afe_spin_go;
  wire logic   [1:0] afe_channel;
  wire logic   adc_go;
  wire logic   conv_active;
  int          n_fail;
  int          cmp_count;
  int          cyc;
  int          d;
  logic [1:0]  ch_log[$];
  logic [1:0]  pend[$];
  int          spin_t[$];
  int          go_t[$];
  logic [15:0] exp_res[3];
  logic [15:0] got;
  logic [15:0] old_x;
  logic [1:0]  mon_ch;
  logic [1:0]  drift = 2'b00;
  logic [2:0]  md[3]  = '{MODE_TRIG_SLEEP, MODE_TRIG_DUTY, MODE_TRIG_STBY};
  logic [1:0]  src[3] = '{TSRC_SPI, TSRC_ALERT, TSRC_CS};
  int          wk[3]  = '{WAKE_SLEEP_CYC, WAKE_DUTY_CYC, WAKE_STBY_CYC};
  logic [3:0]  sel[2] = '{SEL_XZX, SEL_YZY};
  logic [1:0]  outer[2] = '{CH_X, CH_Y};

  hcs_sequencer u_dut (
    .clock       (clock),
    .rst_b       (rst_b),
    .spi_sclk    (spi_sclk),
    .spi_cs_b    (spi_cs_b),
    .spi_mosi    (spi_mosi),
    .alert_b     (alert_b),
    .adc_data    (adc_data),
    .spi_miso    (spi_miso),
    .spi_miso_oe (spi_miso_oe),
    .afe_spin_go (afe_spin_go),
    .afe_channel (afe_channel),
    .adc_go      (adc_go),
    .conv_active (conv_active)
  );

  hcs_spi_host u_host (
    .clock    (clock),
    .spi_miso (spi_miso),
    .spi_sclk (spi_sclk),
    .spi_cs_b (spi_cs_b),
    .spi_mosi (spi_mosi)
  );

  always #2 clock = ~clock;

  // Reference model: channel order, timing and the value each conversion delivers
  always @(posedge clock) begin
    cyc++;
    #1;
    if (afe_spin_go === 1'b1) begin
      ch_log.push_back(afe_channel);
      pend.push_back(afe_channel);
      spin_t.push_back(cyc);
    end
    if (adc_go === 1'b1) begin
      go_t.push_back(cyc);
      if (pend.size() > 0) begin
        mon_ch = pend.pop_front();
        adc_data = 16'($urandom_range(0, 16383)) - 16'h2000;
        exp_res[mon_ch] = adc_data + ((drift == 2'b00) ? 16'h0000 : 16'($signed(adc_data) >>> (8 - drift)));
      end
    end
  end

  task automatic print_verdict;
    if (n_fail == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic timeout(input string name);
    n_fail++;
    $display("MISMATCH %s expected done seen timeout", name);
    print_verdict();
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] v);
    logic [15:0] r;
    u_host.xfer({1'b0, a, v}, r);
  endtask

  task automatic rd(input logic [6:0] a, output logic [15:0] v);
    u_host.xfer({1'b1, a, 16'h0000}, v);
  endtask

  function automatic logic [15:0] mk_cfg(input logic [2:0] m, input logic [1:0] s);
    hcs_dev_cfg_t c;
    c = '{pad_hi: 6'h00, drift_comp: drift, pad_mid: 1'b0, mode: m, pad_lo: 2'b00, trig_src: s};
    return c;
  endfunction

  function automatic logic [15:0] exp_vlen();
    int ax;
    int ay;
    ax = $signed(exp_res[CH_X]);
    ay = $signed(exp_res[CH_Y]);
    if (ax < 0) ax = -ax;
    if (ay < 0) ay = -ay;
    return (ax > ay) ? 16'(ax + ay / 2) : 16'(ay + ax / 2);
  endfunction

  task automatic wait_spin(output int n);
    int n0;
    n0 = spin_t.size();
    n = 0;
    while (spin_t.size() == n0 && n < 3000) begin
      @(posedge clock);
      #2;
      n++;
    end
    if (n >= 3000) timeout("spin_start");
  endtask

  task automatic wait_idle();
    int k;
    int n;
    k = 0;
    repeat (8) @(posedge clock);
    #1;
    while (conv_active !== 1'b0 && k < 5000) begin
      @(posedge clock);
      #1;
      k++;
    end
    if (k >= 5000) timeout("idle");
    n = spin_t.size();
    repeat (200) @(posedge clock);
    #1;
    chk("spins_while_idle", 16'(n), 16'(spin_t.size()));
  endtask

  task automatic pulse_alert();
    alert_b = 1'b0;
    repeat (10) @(posedge clock);
    #1;
    alert_b = 1'b1;
  endtask

  task automatic check_results();
    rd(ADDR_X_RES, got);
    chk("x_result", exp_res[CH_X], got);
    rd(ADDR_Y_RES, got);
    chk("y_result", exp_res[CH_Y], got);
    rd(ADDR_Z_RES, got);
    chk("z_result", exp_res[CH_Z], got);
    rd(ADDR_VLEN, got);
    chk("vector_length", exp_vlen(), got);
  endtask

  initial begin
    clock = 1'b0;
    rst_b = 1'b0;
    alert_b = 1'b1;
    n_fail = 0;
    cmp_count = 0;
    void'($urandom(88));
    repeat (3) @(posedge clock);
    #1;
    rst_b = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    chk("miso_oe_idle", 16'h0000, {15'h0000, spi_miso_oe});
    rd(ADDR_DEV_CFG, got);
    chk("config_reset", DEV_CFG_RST, got);
    rd(ADDR_VLEN, got);
    chk("vector_length_reset", VLEN_RST, got);
    wr(ADDR_VLEN, 16'h1234);
    rd(ADDR_VLEN, got);
    chk("vector_length_ro", VLEN_RST, got);
    rd(7'h7f, got);
    chk("unmapped_read", 16'h0000, got);
    // Pseudo-simultaneous sequences
    for (int k = 0; k < 2; k++) begin
      wr(ADDR_SENS_CFG, {12'h000, sel[k]});
      ch_log.delete();
      go_t.delete();
      wr(ADDR_TRIGGER, 16'h0001);
      wait_idle();
      chk("pseudo_len", 16'h0003, 16'(ch_log.size()));
      chk("pseudo_first", 16'(outer[k]), 16'(ch_log[0]));
      chk("pseudo_mid", 16'(CH_Z), 16'(ch_log[1]));
      chk("pseudo_last", 16'(outer[k]), 16'(ch_log[2]));
      chk("mid_first_gap", 16'(SPIN_CYC), 16'(go_t[1] - go_t[0]));
      chk("mid_second_gap", 16'(SPIN_CYC), 16'(go_t[2] - go_t[1]));
    end
    check_results();
    // Triggered modes, one trigger source each
    wr(ADDR_SENS_CFG, 16'h0007);
    for (int i = 0; i < 3; i++) begin
      wr(ADDR_DEV_CFG, mk_cfg(md[i], src[i]));
      old_x = exp_res[CH_X];
      if (src[i] == TSRC_SPI) begin
        wr(ADDR_TRIGGER, 16'h0001);
        fork
          wait_spin(d);
          rd(ADDR_X_RES, got);
        join
        chk("x_before_done", old_x, got);
      end else if (src[i] == TSRC_ALERT) begin
        fork
          wait_spin(d);
          pulse_alert();
        join
      end else begin
        fork
          wait_spin(d);
          rd(ADDR_STATUS, got);
          begin
            repeat (40) @(posedge clock);
            #1;
            chk("miso_oe_active", 16'h0001, {15'h0000, spi_miso_oe});
          end
        join
      end
      chk("wake_delay_ok", 16'h0001, {15'h0000, d >= wk[i] - 2 && d <= wk[i] + 10});
      wait_idle();
      if (src[i] == TSRC_CS) begin
        wr(ADDR_DEV_CFG, mk_cfg(MODE_TRIG_STBY, TSRC_SPI));
        wait_idle();
      end
      check_results();
    end
    // Continuous conversion of X alone
    wr(ADDR_SENS_CFG, 16'h0001);
    spin_t.delete();
    go_t.delete();
    wr(ADDR_DEV_CFG, mk_cfg(MODE_CONT, TSRC_SPI));
    repeat (600) @(posedge clock);
    #1;
    chk("cont_runs", 16'h0001, {15'h0000, spin_t.size() >= 8});
    chk("cont_rate", 16'h0001, {15'h0000, spin_t[1] - spin_t[0] <= SPIN_CYC + 3});
    chk("cont_overlap", 16'h0001, {15'h0000, spin_t[1] < go_t[0] + CONV_CYC});
    wr(ADDR_DEV_CFG, mk_cfg(MODE_TRIG_STBY, TSRC_SPI));
    wait_idle();
    check_results();
    // Continuous X, Z, X with drift compensation on
    drift = 2'b01;
    wr(ADDR_SENS_CFG, {12'h000, SEL_XZX});
    spin_t.delete();
    wr(ADDR_DEV_CFG, mk_cfg(MODE_CONT, TSRC_SPI));
    repeat (400) @(posedge clock);
    #1;
    chk("pseudo_cont_gap", 16'(SPIN_CYC), 16'(spin_t[1] - spin_t[0]));
    chk("pseudo_cont_wrap", 16'(SPIN_CYC), 16'(spin_t[3] - spin_t[2]));
    wr(ADDR_DEV_CFG, mk_cfg(MODE_TRIG_STBY, TSRC_SPI));
    wait_idle();
    check_results();
    print_verdict();
  end
endmodule
`default_nettype wire
